// ### rtl/lldram_pin_map.vh
`ifndef LLDRAM_PIN_MAP_VH
`define LLDRAM_PIN_MAP_VH
`define CMD_READ 2'h0
`define CMD_WRITE 2'h1
`define CMD_RENEW 2'h2
`define CMD_CONFIG 2'h3
`define CFG_ZQ_BIT 8
`define CFG_RESET 21'h00_0000
`define RD_LATENCY 4'h4
`define MRS_WAIT_CYC 4'h6
`define W_X9 2'h0
`define W_X18 2'h1
`define W_X36 2'h2
`endif

// ### rtl/edge_finder.v
`timescale 1ns/1ps
`default_nettype none
module edge_finder (
   // Clock and reset
   input wire mclk_i,
   input wire arst_n_i,
   // Outside level
   input wire level_i,
   // Synchronised level and edges
   output reg level_o,
   output wire rise_o,
   output wire fall_o
);
   reg meta;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta <= 1'b0;
         level_o <= 1'b0;
      end else begin
         meta <= level_i;
         level_o <= meta;
      end
   end
   reg prev;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev <= 1'b0;
      end else begin
         prev <= level_o;
      end
   end
   assign rise_o = level_o & ~prev;
   assign fall_o = ~level_o & prev;
endmodule
`default_nettype wire

// ### rtl/lldram_pin_if.v
`timescale 1ns/1ps
`default_nettype none
`include "lldram_pin_map.vh"
module lldram_pin_if #(
   parameter AW = 21,
   parameter DW = 36,
   parameter DEPTH = 64
) (
   // Clock and reset
   input wire mclk_i,
   input wire arst_n_i,
   // Width strap
   input wire [1:0] width_sel_i,
   // Command clock and command pins
   input wire cmd_clock_i,
   input wire cmd_clock_complement_i,
   input wire chip_sel_n_i,
   input wire write_cmd_n_i,
   input wire renew_cmd_n_i,
   input wire [AW-1:0] location_inputs_i,
   input wire [2:0] bank_select_i,
   // Write strobes and mask
   input wire [1:0] write_strobe_i,
   input wire [1:0] write_strobe_complement_i,
   input wire write_mask_i,
   // Data pins
   input wire [DW-1:0] data_io_i,
   output reg [DW-1:0] data_io_o,
   output reg data_io_oe_n_o,
   // Read strobes and valid
   output reg [1:0] read_strobe_o,
   output reg [1:0] read_strobe_complement_o,
   output reg read_valid_o,
   // Drive reference status
   output reg fixed_drive_ref_o
);
   function [DW-1:0] width_mask;
      input [1:0] w;
      begin
         if (w == `W_X9) begin
            width_mask = {{(DW-9){1'b0}}, 9'h1ff};
         end else if (w == `W_X18) begin
            width_mask = {{(DW-18){1'b0}}, 18'h3_ffff};
         end else begin
            width_mask = {DW{1'b1}};
         end
      end
   endfunction
   function [3:0] burst_len;
      input [1:0] w;
      begin
         if (w == `W_X9) begin
            burst_len = 4'h2;
         end else if (w == `W_X18) begin
            burst_len = 4'h4;
         end else begin
            burst_len = 4'h8;
         end
      end
   endfunction
   function [AW-1:0] loc_mask;
      input [1:0] w;
      begin
         if (w == `W_X36) begin
            loc_mask = {2'h0, {(AW-2){1'b1}}};
         end else if (w == `W_X18) begin
            loc_mask = {1'b0, {(AW-1){1'b1}}};
         end else begin
            loc_mask = {AW{1'b1}};
         end
      end
   endfunction
   // Synchronisers for all pins but the width strap and the two complement inputs
   wire ck_lvl, ck_rise, ck_fall;
   wire dk0_lvl, dk0_rise, dk0_fall;
   wire dk1_lvl, dk1_rise, dk1_fall;
   edge_finder u_ck (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .level_i(cmd_clock_i),
      .level_o(ck_lvl), .rise_o(ck_rise), .fall_o(ck_fall));
   edge_finder u_dk0 (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .level_i(write_strobe_i[0]),
      .level_o(dk0_lvl), .rise_o(dk0_rise), .fall_o(dk0_fall));
   edge_finder u_dk1 (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .level_i(write_strobe_i[1]),
      .level_o(dk1_lvl), .rise_o(dk1_rise), .fall_o(dk1_fall));
   reg [AW+3+3+DW:0] p_meta, p_sync;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         p_meta <= {(AW+DW+7){1'b0}};
         p_sync <= {(AW+DW+7){1'b0}};
      end else begin
         p_meta <= {write_mask_i, data_io_i, bank_select_i, chip_sel_n_i, write_cmd_n_i,
            renew_cmd_n_i, location_inputs_i};
         p_sync <= p_meta;
      end
   end
   wire [AW-1:0] s_loc = p_sync[AW-1:0];
   wire s_ref_n = p_sync[AW];
   wire s_we_n = p_sync[AW+1];
   wire s_cs_n = p_sync[AW+2];
   wire [2:0] s_bank = p_sync[AW+5:AW+3];
   wire [DW-1:0] s_dq = p_sync[AW+DW+5:AW+6];
   wire s_dm = p_sync[AW+DW+6];
   reg [1:0] width;
   reg width_taken;
   reg [AW-1:0] cfg;
   reg [DW-1:0] mem [0:DEPTH-1];
   // Command capture
   localparam ST_IDLE = 2'h0;
   localparam ST_READ = 2'h1;
   localparam ST_WRITE = 2'h2;
   reg [1:0] state;
   reg [3:0] words;
   reg [3:0] lat;
   reg [5:0] ptr;
   reg [DW-1:0] rd_word;
   reg rd_launch;
   wire [AW-1:0] loc_used = s_loc & loc_mask(width);
   wire [5:0] base = loc_used[5:0] ^ {s_bank, 3'h0};
   wire cmd_ok = ck_rise && !s_cs_n;
   wire [1:0] cmd = (!s_we_n && s_ref_n) ? `CMD_WRITE :
      (s_we_n && !s_ref_n) ? `CMD_RENEW :
      (!s_we_n && !s_ref_n) ? `CMD_CONFIG : `CMD_READ;
   wire wr_edge = (width == `W_X36) ? (dk1_rise | dk1_fall) : (dk0_rise | dk0_fall);
   wire [DW-1:0] wmask = width_mask(width);
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         width <= `W_X9;
         width_taken <= 1'b0;
         cfg <= `CFG_RESET;
         state <= ST_IDLE;
         words <= 4'h0;
         lat <= 4'h0;
         ptr <= 6'h00;
         rd_word <= {DW{1'b0}};
         rd_launch <= 1'b0;
         fixed_drive_ref_o <= 1'b1;
      end else begin
         // Launch flag stands until the next command clock edge puts the word out
         if (ck_rise || ck_fall) begin
            rd_launch <= 1'b0;
         end
         if (!width_taken) begin
            width <= width_sel_i;
            width_taken <= 1'b1;
         end
         fixed_drive_ref_o <= ~cfg[`CFG_ZQ_BIT];
         if (cmd_ok && cmd == `CMD_CONFIG) begin
            cfg <= s_loc;
         end
         case (state)
            ST_IDLE: begin
               if (cmd_ok && cmd == `CMD_READ) begin
                  state <= ST_READ;
                  ptr <= base;
                  lat <= `RD_LATENCY;
                  words <= burst_len(width);
               end else if (cmd_ok && cmd == `CMD_WRITE) begin
                  state <= ST_WRITE;
                  ptr <= base;
                  words <= burst_len(width);
               end
            end
            ST_READ: begin
               // Runs on regardless of chip select
               if (lat != 4'h0) begin
                  if (ck_rise || ck_fall) begin
                     lat <= lat - 4'h1;
                  end
               end else if (ck_rise || ck_fall) begin
                  rd_word <= mem[ptr] & wmask;
                  rd_launch <= 1'b1;
                  ptr <= ptr + 6'h01;
                  words <= words - 4'h1;
                  if (words == 4'h1) begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_WRITE: begin
               if (wr_edge) begin
                  ptr <= ptr + 6'h01;
                  words <= words - 4'h1;
                  if (words == 4'h1) begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
   always @(posedge mclk_i) begin
      if (state == ST_WRITE && wr_edge && !s_dm) begin
         mem[ptr] <= s_dq & wmask;
      end
   end
   // Read strobes follow the command clock continuously, except strobe 1, which is held low in x9 mode
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         read_strobe_o <= 2'h0;
         read_strobe_complement_o <= 2'h3;
         read_valid_o <= 1'b0;
         data_io_o <= {DW{1'b0}};
         data_io_oe_n_o <= 1'b1;
      end else begin
         read_strobe_o <= (width == `W_X9) ? {1'b0, ck_lvl} : {ck_lvl, ck_lvl};
         read_strobe_complement_o <= (width == `W_X9) ? {1'b1, ~ck_lvl} : {~ck_lvl, ~ck_lvl};
         if (ck_rise || ck_fall) begin
            read_valid_o <= rd_launch;
            data_io_oe_n_o <= ~rd_launch;
            if (rd_launch) begin
               data_io_o <= rd_word;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/lldram_pin_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "lldram_pin_map.vh"
module lldram_pin_props #(
   parameter DW = 36
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Watched pins
   input wire logic [1:0] width_sel_i,
   input wire logic [DW-1:0] data_io_o,
   input wire logic data_io_oe_n_o,
   input wire logic [1:0] read_strobe_o,
   input wire logic [1:0] read_strobe_complement_o,
   input wire logic read_valid_o,
   input wire logic fixed_drive_ref_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   logic [3:0] words;
   logic [1:0] up;
   // Width strap settles two clocks after reset
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         up <= 2'h0;
      end else begin
         up <= {up[0], 1'b1};
      end
   end
   // Words seen in the running burst
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         words <= 4'h0;
      end else if (!read_valid_o) begin
         words <= 4'h0;
      end else if ($changed(read_strobe_o[0])) begin
         words <= words + 4'h1;
      end
   end
   AST_STROBE_PAIR: assert property (read_strobe_complement_o[0] == !read_strobe_o[0])
      else $error("read strobe pair not complementary");
   AST_STROBE_RUNS: assert property (1'b1 |-> ##[1:12] $changed(read_strobe_o[0]))
      else $error("read strobe stopped");
   AST_X9_STROBE1: assert property (up[1] && width_sel_i == `W_X9 |-> read_strobe_o[1] == 1'b0)
      else $error("upper read strobe moves in narrow mode");
   AST_STROBE1_ALIGN: assert property (up[1] && width_sel_i != `W_X9 |-> read_strobe_o[1] == read_strobe_o[0])
      else $error("read strobes not aligned");
   AST_VALID_AT_EDGE: assert property ($changed(read_valid_o) |-> $changed(read_strobe_o[0]))
      else $error("read valid moved off a strobe edge");
   AST_DATA_AT_EDGE: assert property (!data_io_oe_n_o && $changed(data_io_o) |-> $changed(read_strobe_o[0]))
      else $error("read data moved off a strobe edge");
   AST_OE_WITH_VALID: assert property (read_valid_o |-> !data_io_oe_n_o)
      else $error("valid word without driven bus");
   AST_BURST_LEN: assert property ($fell(read_valid_o) |-> words == (4'h2 << width_sel_i))
      else $error("burst word count wrong");
   cover property ($rose(read_valid_o));
   cover property ($fell(read_valid_o) && width_sel_i == `W_X36);
   cover property ($fell(fixed_drive_ref_o));
endmodule
`default_nettype wire

// ### sim/mem_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
   // Clocks
   input wire logic mclk_i,
   output logic ck_o,
   // Command pins
   output logic [2:0] cmd_o,
   output logic [20:0] loc_o,
   output logic [2:0] bank_o,
   // Write side
   output logic [1:0] dk_o,
   output logic dm_o,
   output logic [35:0] dq_o,
   // Read side
   input wire logic [1:0] qk_i,
   input wire logic read_valid_i,
   input wire logic [35:0] q_i
);
   logic [35:0] wdat [8];
   logic [35:0] q [$];
   logic ps = 1'b0;
   initial begin
      ck_o = 1'b0;
      cmd_o = 3'h7;
      loc_o = 21'h00_0000;
      bank_o = 3'h0;
      dk_o = 2'h0;
      dm_o = 1'b0;
      dq_o = 36'h0;
      #13;
      forever #200 ck_o = ~ck_o;
   end
   // Capture by strobe and valid only
   always @(negedge mclk_i) begin
      if (read_valid_i && qk_i[0] !== ps) q.push_back(q_i);
      ps = qk_i[0];
   end
   task automatic cmd(input logic [2:0] c, input logic [20:0] a, input logic [2:0] b);
      @(negedge ck_o);
      @(posedge mclk_i);
      #2;
      cmd_o = c;
      loc_o = a;
      bank_o = b;
      @(negedge ck_o);
      @(posedge mclk_i);
      #2;
      cmd_o = 3'h7;
      loc_o = ~a;
   endtask
   task automatic wr(input int n, input logic [1:0] s, input int mp);
      for (int k = 0; k < n; k++) begin
         @(posedge mclk_i);
         #2;
         dq_o = wdat[k];
         dm_o = (k == mp);
         repeat (2) @(posedge mclk_i);
         #2;
         dk_o = dk_o ^ s;
         @(posedge mclk_i);
      end
      #2;
      dq_o = ~dq_o;
      dm_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [1:0] width_sel_i = 2'h0;
   wire logic ck, dm, read_valid, oe_n, fix_ref;
   wire logic [2:0] cmd, bank;
   wire logic [20:0] loc;
   wire logic [1:0] dk, qk, qkn;
   wire logic [35:0] dq, q;
   logic [35:0] exp_mem [64];
   int err_total = 0;
   int tests_run = 0;
   integer seed = 32'h35f1;
   always #25 mclk_i = ~mclk_i;
   lldram_pin_if lldram_pin_if_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .width_sel_i(width_sel_i),
      .cmd_clock_i(ck), .cmd_clock_complement_i(~ck), .chip_sel_n_i(cmd[2]), .write_cmd_n_i(cmd[1]),
      .renew_cmd_n_i(cmd[0]), .location_inputs_i(loc), .bank_select_i(bank), .write_strobe_i(dk),
      .write_strobe_complement_i(~dk), .write_mask_i(dm), .data_io_i(dq), .data_io_o(q), .data_io_oe_n_o(oe_n),
      .read_strobe_o(qk), .read_strobe_complement_o(qkn), .read_valid_o(read_valid), .fixed_drive_ref_o(fix_ref));
   mem_ctrl_model mem_ctrl_model_i (.mclk_i(mclk_i), .ck_o(ck), .cmd_o(cmd), .loc_o(loc), .bank_o(bank),
      .dk_o(dk), .dm_o(dm), .dq_o(dq), .qk_i(qk), .read_valid_i(read_valid), .q_i(q));
   task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] want);
      tests_run++;
      if (seen !== want) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cfg(input logic [20:0] a, input logic want);
      mem_ctrl_model_i.cmd(3'h0, a, 3'h0);
      repeat (6) @(posedge ck);
      chk("fixed_drive_ref_o", 36'(fix_ref), 36'(want));
   endtask
   initial begin
      #300_000;
      err_total++;
      wrap_up;
   end
   initial begin
      logic [20:0] a;
      logic [2:0] b;
      logic [35:0] m;
      int bl, idx, mp;
      for (int w = 0; w < 3; w++) begin
         @(posedge mclk_i);
         #2;
         arst_n_i = 1'b0;
         width_sel_i = w[1:0];
         repeat (12) @(posedge mclk_i);
         #2;
         arst_n_i = 1'b1;
         repeat (4) @(posedge mclk_i);
         chk("fixed_drive_ref_o", 36'(fix_ref), 36'h1);
         cfg(21'h00_0100, 1'b0);
         cfg(21'h00_0000, 1'b1);
         bl = 2 << w;
         m = (36'h1 << (9 << w)) - 36'h1;
         a = $random(seed);
         a[2:0] = 3'h0;
         b = $random(seed);
         idx = a[5:0] ^ {b, 3'h0};
         for (int p = 0; p < 2; p++) begin
            mp = p ? $unsigned($random(seed)) % bl : -1;
            for (int k = 0; k < bl; k++) begin
               mem_ctrl_model_i.wdat[k] = {$random(seed), $random(seed)} & m;
               if (k != mp) exp_mem[idx + k] = mem_ctrl_model_i.wdat[k];
            end
            mem_ctrl_model_i.cmd(3'h1, a, b);
            mem_ctrl_model_i.wr(bl, w == 2 ? 2'h2 : 2'h1, mp);
         end
         mem_ctrl_model_i.q.delete();
         mem_ctrl_model_i.cmd(3'h2, a, b);
         mem_ctrl_model_i.cmd(3'h7, a, b);
         repeat (8) @(posedge ck);
         chk("ignored read", 36'(mem_ctrl_model_i.q.size()), 36'h0);
         mem_ctrl_model_i.cmd(3'h7 ^ 3'h4, a ^ (w == 2 ? 21'h18_0000 : w == 1 ? 21'h10_0000 : 21'h0), b);
         repeat (8) @(posedge ck);
         chk("burst length", 36'(mem_ctrl_model_i.q.size()), 36'(bl));
         for (int k = 0; k < bl; k++) chk("read word", mem_ctrl_model_i.q[k] & m, exp_mem[idx + k]);
      end
      wrap_up;
   end
endmodule
bind lldram_pin_if lldram_pin_props #(.DW(DW)) props_i (.*);
`default_nettype wire
